// [rtl/io_adapter_pkg.sv]
package io_adapter_pkg;
  // ==========================================
  // widths and register select codes
  localparam int         DATA_W     = 8;
  localparam logic [1:0] SEL_A_PORT = 2'h0;
  localparam logic [1:0] SEL_A_CTRL = 2'h1;
  localparam logic [1:0] SEL_B_PORT = 2'h2;
  localparam logic [1:0] SEL_B_CTRL = 2'h3;

  // ==========================================
  // control register field positions
  localparam int CTL_FLAG1    = 7;
  localparam int CTL_FLAG2    = 6;
  localparam int CTL_AUX_OUT  = 5;
  localparam int CTL_AUX_EDGE = 4;
  localparam int CTL_AUX_EN   = 3;
  localparam int CTL_DIR_ACC  = 2;
  localparam int CTL_EV_EDGE  = 1;
  localparam int CTL_EV_EN    = 0;

  // ==========================================
  // reset values
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [7:0] DIR_RST  = 8'h00;
  localparam logic [7:0] OUT_RST  = 8'h00;

  // ==========================================
  // types
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b00,
    BUS_HOLD   = 2'b01,
    BUS_COMMIT = 2'b10
  } busState_t;

  typedef struct packed {
    logic       wrCtrl;
    logic       wrPort;
    logic       rdPort;
    logic [7:0] data;
  } sideCmd_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] dir;
    logic [7:0] portRd;
  } sideView_t;
endpackage

// [rtl/pin_sync.sv]
module pin_sync
  import io_adapter_pkg::*;
#(
  parameter int WIDTH = 1
)(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // pins in, synchronised copy out
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] syncOut
);
  // ==========================================
  // two stages; only the second stage is seen outside
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      meta_q  <= '0;
      syncOut <= '0;
    end
    else
    begin
      meta_q  <= pinIn;
      syncOut <= meta_q;
    end
  end
endmodule

// [rtl/side_unit.sv]
module side_unit
  import io_adapter_pkg::*;
#(
  parameter bit READ_PINS = 1'b1
)(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // bus commands
  input  wire sideCmd_t   cmd,
  output sideView_t       view,
  // synchronised peripheral inputs
  input  wire logic       eventIn,
  input  wire logic       auxIn,
  input  wire logic [7:0] portPins,
  // peripheral drivers
  output logic [7:0]      portOut,
  output logic [7:0]      portOeN,
  output logic            auxOut,
  output logic            auxOeN,
  output logic            irqOeN
);
  // ==========================================
  // registers
  logic [5:0] ctrl_q;
  logic [7:0] dir_q;
  logic       flag1_q;
  logic       flag2_q;
  logic       event_q;
  logic       aux_q;
  logic       evHit;
  logic       auxHit;
  logic       clrFlags;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ctrl_q  <= CTRL_RST;
      dir_q   <= DIR_RST;
      portOut <= OUT_RST;
    end
    else
    begin
      if (cmd.wrCtrl)
        ctrl_q <= cmd.data[5:0];
      if (cmd.wrPort && ctrl_q[CTL_DIR_ACC])
        portOut <= cmd.data;
      if (cmd.wrPort && !ctrl_q[CTL_DIR_ACC])
        dir_q <= cmd.data;
    end
  end

  // ==========================================
  // edge detection, polarity picked by control bits
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      event_q <= 1'b0;
      aux_q   <= 1'b0;
    end
    else
    begin
      event_q <= eventIn;
      aux_q   <= auxIn;
    end
  end

  assign evHit  = ctrl_q[CTL_EV_EDGE] ? (eventIn && !event_q) : (!eventIn && event_q);
  assign auxHit = !ctrl_q[CTL_AUX_OUT] &&
                  (ctrl_q[CTL_AUX_EDGE] ? (auxIn && !aux_q) : (!auxIn && aux_q));
  assign clrFlags = cmd.rdPort && ctrl_q[CTL_DIR_ACC];

  // ==========================================
  // flags: a new edge wins over a clearing read
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      flag1_q <= 1'b0;
      flag2_q <= 1'b0;
    end
    else
    begin
      flag1_q <= (flag1_q && !clrFlags) || evHit;
      flag2_q <= (flag2_q && !clrFlags) || auxHit;
    end
  end

  // ==========================================
  // pins and views
  assign portOeN = ~dir_q;
  assign auxOut  = ctrl_q[CTL_AUX_EN];
  assign auxOeN  = !ctrl_q[CTL_AUX_OUT];
  assign irqOeN  = !((flag1_q && ctrl_q[CTL_EV_EN]) ||
                     (flag2_q && ctrl_q[CTL_AUX_EN]));
  assign view.ctrl   = {flag1_q, flag2_q, ctrl_q};
  assign view.dir    = dir_q;
  // side b returns its own latch on output lines, so a loaded pin never misreads
  assign view.portRd = READ_PINS ? portPins : ((portOut & dir_q) | (portPins & ~dir_q));
endmodule

// [rtl/io_adapter.sv]
module io_adapter
  import io_adapter_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       resetNInput,
  // processor bus
  input  wire logic       phaseTwo,
  input  wire logic       readNotWrite,
  input  wire logic       selectHighFirst,
  input  wire logic       selectHighSecond,
  input  wire logic       selectLowThirdN,
  input  wire logic       regPickLow,
  input  wire logic       regPickHigh,
  input  wire logic [7:0] hostBusLinesIn,
  output logic      [7:0] hostBusLinesOut,
  output logic            hostBusLinesOeN,
  // interrupt requests, open drain
  output logic            sideAIrqNOut,
  output logic            sideAIrqNOeN,
  output logic            sideBIrqNOut,
  output logic            sideBIrqNOeN,
  // side a peripheral
  input  wire logic       sideAEventIn,
  input  wire logic       sideAAuxLineIn,
  output logic            sideAAuxLineOut,
  output logic            sideAAuxLineOeN,
  input  wire logic [7:0] sideAPortIn,
  output logic      [7:0] sideAPortOut,
  output logic      [7:0] sideAPortOeN,
  // side b peripheral
  input  wire logic       sideBEventIn,
  input  wire logic       sideBAuxLineIn,
  output logic            sideBAuxLineOut,
  output logic            sideBAuxLineOeN,
  input  wire logic [7:0] sideBPortIn,
  output logic      [7:0] sideBPortOut,
  output logic      [7:0] sideBPortOeN
);
  // ==========================================
  // pin synchronisers
  logic [7:0]  busS;
  logic [1:0]  evS;
  logic [1:0]  auxS;
  logic [15:0] portS;
  logic [7:0]  ctlS;
  logic        phiS;
  logic        rwS;
  logic        selS;
  logic [1:0]  rsS;
  logic        resetNS;
  logic        resetNRaw;
  logic        intRst;

  pin_sync #(.WIDTH(8)) u_busSync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pinIn   (hostBusLinesIn),
    .syncOut (busS)
  );

  pin_sync #(.WIDTH(20)) u_perSync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pinIn   ({sideBPortIn, sideAPortIn, sideBAuxLineIn, sideAAuxLineIn, sideBEventIn, sideAEventIn}),
    .syncOut ({portS, auxS, evS})
  );

  pin_sync #(.WIDTH(8)) u_ctlSync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pinIn   ({!resetNInput, phaseTwo, readNotWrite, selectHighFirst, selectHighSecond,
               selectLowThirdN, regPickHigh, regPickLow}),
    .syncOut (ctlS)
  );

  // reset pin enters inverted, so a cleared synchroniser reads as released and rst leaves no tail
  assign resetNRaw = !ctlS[7];
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      resetNS <= 1'b1;
    else
      resetNS <= resetNRaw;
  end

  assign phiS   = ctlS[6];
  assign rwS    = ctlS[5];
  assign selS   = ctlS[4] && ctlS[3] && !ctlS[2];
  assign rsS    = ctlS[1:0];
  assign intRst = rst || !resetNS;

  // ==========================================
  // phase-two cycle sequencer
  busState_t  state_q;
  logic       phiPrev_q;
  logic       rw_q;
  logic [1:0] rs_q;
  logic [7:0] hold_q;
  logic       commit;

  always_ff @(posedge sys_clk)
  begin
    if (intRst)
      phiPrev_q <= 1'b0;
    else
      phiPrev_q <= phiS;
  end

  always_ff @(posedge sys_clk)
  begin
    if (intRst)
      state_q <= BUS_IDLE;
    else
    begin
      case (state_q)
        BUS_IDLE:
          if (phiS && !phiPrev_q && selS)
            state_q <= BUS_HOLD;
        BUS_HOLD:
          if (!phiS)
            state_q <= BUS_COMMIT;
        BUS_COMMIT:
          state_q <= BUS_IDLE;
        default:
          state_q <= BUS_IDLE;
      endcase
    end
  end

  // direction and register select are taken at the rising phase-two edge
  always_ff @(posedge sys_clk)
  begin
    if (intRst)
    begin
      rw_q <= 1'b1;
      rs_q <= SEL_A_PORT;
    end
    else if (state_q == BUS_IDLE && phiS && !phiPrev_q && selS)
    begin
      rw_q <= rwS;
      rs_q <= rsS;
    end
  end

  // input holding register follows the bus while phase two is high
  always_ff @(posedge sys_clk)
  begin
    if (intRst)
      hold_q <= 8'h00;
    else if (state_q == BUS_HOLD && phiS)
      hold_q <= busS;
  end

  assign commit = (state_q == BUS_COMMIT);

  // ==========================================
  // two sides
  sideCmd_t   cmd   [2];
  sideView_t  view  [2];
  logic [7:0] pOut  [2];
  logic [7:0] pOeN  [2];
  logic [1:0] aOut;
  logic [1:0] aOeN;
  logic [1:0] iOeN;

  genvar s;
  generate
    for (s = 0; s < 2; s++)
    begin : g_side
      assign cmd[s].wrCtrl = commit && !rw_q && rs_q[1] == 1'(s) && rs_q[0];
      assign cmd[s].wrPort = commit && !rw_q && rs_q[1] == 1'(s) && !rs_q[0];
      assign cmd[s].rdPort = commit && rw_q && rs_q[1] == 1'(s) && !rs_q[0];
      assign cmd[s].data   = hold_q;

      side_unit #(.READ_PINS(s == 0)) u_side (
        .sys_clk  (sys_clk),
        .rst      (intRst),
        .cmd      (cmd[s]),
        .view     (view[s]),
        .eventIn  (evS[s]),
        .auxIn    (auxS[s]),
        .portPins (portS[8*s +: 8]),
        .portOut  (pOut[s]),
        .portOeN  (pOeN[s]),
        .auxOut   (aOut[s]),
        .auxOeN   (aOeN[s]),
        .irqOeN   (iOeN[s])
      );
    end
  endgenerate

  // ==========================================
  // read path
  logic [7:0] rdMux;

  always_comb
  begin
    case (rs_q)
      SEL_A_PORT: rdMux = view[0].ctrl[CTL_DIR_ACC] ? view[0].portRd : view[0].dir;
      SEL_A_CTRL: rdMux = view[0].ctrl;
      SEL_B_PORT: rdMux = view[1].ctrl[CTL_DIR_ACC] ? view[1].portRd : view[1].dir;
      SEL_B_CTRL: rdMux = view[1].ctrl;
      default:    rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (intRst)
      hostBusLinesOut <= 8'h00;
    else
      hostBusLinesOut <= rdMux;
  end

  assign hostBusLinesOeN = !(state_q == BUS_HOLD && rw_q);

  // ==========================================
  // pins out; interrupt pins only ever pull low
  assign sideAIrqNOut    = 1'b0;
  assign sideBIrqNOut    = 1'b0;
  assign sideAIrqNOeN    = iOeN[0];
  assign sideBIrqNOeN    = iOeN[1];
  assign sideAAuxLineOut = aOut[0];
  assign sideAAuxLineOeN = aOeN[0];
  assign sideBAuxLineOut = aOut[1];
  assign sideBAuxLineOeN = aOeN[1];
  assign sideAPortOut    = pOut[0];
  assign sideAPortOeN    = pOeN[0];
  assign sideBPortOut    = pOut[1];
  assign sideBPortOeN    = pOeN[1];

  // ==========================================
  // checks
  property p_resetClears;
    @(posedge sys_clk) disable iff (rst)
    !resetNS |=> view[0].ctrl == 8'h00 && view[1].ctrl == 8'h00 && sideAPortOeN == 8'hff
      && sideBPortOeN == 8'hff && sideBPortOut == 8'h00;
  endproperty
  a_resetClears: assert property (p_resetClears) else $error("reset left a register set");

  property p_commitAfterFall;
    @(posedge sys_clk) disable iff (intRst)
    commit |-> $past(state_q) == BUS_HOLD && !$past(phiS);
  endproperty
  a_commitAfterFall: assert property (p_commitAfterFall) else $error("store not after phase two");

  property p_noSelect;
    @(posedge sys_clk) disable iff (intRst)
    state_q == BUS_IDLE && !selS |=> state_q == BUS_IDLE;
  endproperty
  a_noSelect: assert property (p_noSelect) else $error("cycle taken while unselected");

  property p_driveOnlyRead;
    @(posedge sys_clk) disable iff (intRst)
    !hostBusLinesOeN |-> state_q == BUS_HOLD && rw_q && phiPrev_q;
  endproperty
  a_driveOnlyRead: assert property (p_driveOnlyRead) else $error("bus driven outside read");

  property p_readNoWrite;
    @(posedge sys_clk) disable iff (intRst)
    commit && rw_q && rs_q == SEL_A_CTRL |=> $stable(view[0].ctrl[5:0]) && $stable(view[0].dir);
  endproperty
  a_readNoWrite: assert property (p_readNoWrite) else $error("read changed a register");

  property p_dirWrite;
    @(posedge sys_clk) disable iff (intRst)
    commit && !rw_q && rs_q == SEL_B_PORT && !view[1].ctrl[CTL_DIR_ACC]
      |=> view[1].dir == $past(hold_q) && sideBPortOeN == ~$past(hold_q);
  endproperty
  a_dirWrite: assert property (p_dirWrite) else $error("direction write lost");

  property p_readClears;
    @(posedge sys_clk) disable iff (intRst)
    commit && rw_q && rs_q == SEL_A_PORT && view[0].ctrl[CTL_DIR_ACC] && $stable(evS[0]) && $stable(auxS[0])
      |=> view[0].ctrl[7:6] == 2'b00;
  endproperty
  a_readClears: assert property (p_readClears) else $error("port read kept a flag");

  property p_irqLevel;
    @(posedge sys_clk) disable iff (intRst)
    view[1].ctrl[CTL_FLAG1] && view[1].ctrl[CTL_EV_EN] |-> !sideBIrqNOeN && !sideBIrqNOut;
  endproperty
  a_irqLevel: assert property (p_irqLevel) else $error("enabled flag not pulling irq");

  property p_flagsKept;
    @(posedge sys_clk) disable iff (intRst)
    commit && !rw_q && rs_q == SEL_A_CTRL
      |=> (view[0].ctrl[7:6] & $past(view[0].ctrl[7:6])) == $past(view[0].ctrl[7:6]) &&
      view[0].ctrl[5:0] == $past(hold_q[5:0]);
  endproperty
  a_flagsKept: assert property (p_flagsKept) else $error("control write hit flags");
endmodule

// [verification/periph_model.sv]
// ==========================================
// peripheral side of one port: each line shows the device's level
// where the device drives it, else the far device's own value
module periph_model
  import io_adapter_pkg::*;
(
  // device drivers
  input  wire logic [7:0] portOut,
  input  wire logic [7:0] portOeN,
  // far device value and resolved pins
  input  wire logic [7:0] extVal,
  output logic      [7:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // a cleared enable bit means the device owns that line
  assign pins = (portOut & ~portOeN) | (extVal & portOeN);
endmodule

// [verification/dual_port_parallel_io_adapter_bench.sv]
module dual_port_parallel_io_adapter_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import io_adapter_pkg::*;
  // ==========================================
  // stimulus and wires
  logic       sys_clk = 0, rst = 1, resetNInput = 1, phaseTwo = 0, readNotWrite = 1;
  logic       selectHighFirst = 0, selectHighSecond = 0, selectLowThirdN = 1;
  logic       regPickLow = 0, regPickHigh = 0, evtA = 0, evtB = 0, auxA = 0, auxB = 0;
  logic [7:0] busDrv = 8'h00, extA = 8'h00, extB = 8'h00, pinsA, pinsB, busLevel, hostBusLinesOut;
  logic [7:0] aOut, aOeN, bOut, bOeN, rv;
  logic       hostBusLinesOeN, aIrqOut, aIrqOeN, bIrqOut, bIrqOeN, auxAOut, auxAOeN, auxBOut, auxBOeN;
  int         error_cnt = 0, compares = 0;
  // bus level: the device wins while it drives, else the processor's value
  assign busLevel = hostBusLinesOeN ? busDrv : hostBusLinesOut;
  always #2.5 sys_clk = ~sys_clk;

  io_adapter io_adapter_i (.sys_clk(sys_clk), .rst(rst), .resetNInput(resetNInput), .phaseTwo(phaseTwo),
    .readNotWrite(readNotWrite), .selectHighFirst(selectHighFirst), .selectHighSecond(selectHighSecond),
    .selectLowThirdN(selectLowThirdN), .regPickLow(regPickLow), .regPickHigh(regPickHigh),
    .hostBusLinesIn(busLevel), .hostBusLinesOut(hostBusLinesOut), .hostBusLinesOeN(hostBusLinesOeN),
    .sideAIrqNOut(aIrqOut), .sideAIrqNOeN(aIrqOeN), .sideBIrqNOut(bIrqOut), .sideBIrqNOeN(bIrqOeN),
    .sideAEventIn(evtA), .sideAAuxLineIn(auxA), .sideAAuxLineOut(auxAOut), .sideAAuxLineOeN(auxAOeN),
    .sideAPortIn(pinsA), .sideAPortOut(aOut), .sideAPortOeN(aOeN),
    .sideBEventIn(evtB), .sideBAuxLineIn(auxB), .sideBAuxLineOut(auxBOut), .sideBAuxLineOeN(auxBOeN),
    .sideBPortIn(pinsB), .sideBPortOut(bOut), .sideBPortOeN(bOeN));
  periph_model periph_model_i (.portOut(aOut), .portOeN(aOeN), .extVal(extA), .pins(pinsA));
  periph_model periph_b_i (.portOut(bOut), .portOeN(bOeN), .extVal(extB), .pins(pinsB));

  // ==========================================
  // checking and bus cycles
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // cs is {first, second, thirdN}; only 3'b110 selects the device
  task automatic bus(input logic rw, input logic [1:0] rs, input logic [7:0] wd, input logic [2:0] cs,
                     output logic [7:0] rd);
    @(negedge sys_clk);
    readNotWrite = rw;
    {regPickHigh, regPickLow} = rs;
    {selectHighFirst, selectHighSecond, selectLowThirdN} = cs;
    busDrv = wd;
    repeat (2) @(negedge sys_clk);
    phaseTwo = 1;
    repeat (7) @(negedge sys_clk);
    rd = hostBusLinesOut;
    chk({7'h0, hostBusLinesOeN}, {7'h0, !(rw && cs == 3'b110)});
    phaseTwo = 0;
    repeat (7) @(negedge sys_clk);
    chk({7'h0, hostBusLinesOeN}, 8'h01);
    {selectHighFirst, selectHighSecond, selectLowThirdN} = 3'b001;
    readNotWrite = 1;
    busDrv = ~wd;
    repeat (2) @(negedge sys_clk);
  endtask

  task automatic wr(input logic [1:0] rs, input logic [7:0] d);
    bus(1'b0, rs, d, 3'b110, rv);
  endtask

  task automatic rdChk(input logic [1:0] rs, input logic [7:0] exp);
    bus(1'b1, rs, 8'h00, 3'b110, rv);
    chk(rv, exp);
  endtask

  task automatic pulse(input bit sideB, input bit aux = 1'b0);
    @(negedge sys_clk);
    if (aux) auxA = ~auxA;
    else if (sideB) evtB = ~evtB;
    else evtA = ~evtA;
    repeat (6) @(negedge sys_clk);
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset;
    rdChk(SEL_A_CTRL, 8'h00);
    rdChk(SEL_B_CTRL, 8'h00);
    chk(aOeN, 8'hff);
    chk(bOut, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_dir;
    wr(SEL_A_CTRL, 8'h00);
    wr(SEL_A_PORT, 8'h0f);
    rdChk(SEL_A_PORT, 8'h0f);
    chk(aOeN, 8'hf0);
    wr(SEL_B_CTRL, 8'h00);
    wr(SEL_B_PORT, 8'hf0);
    chk(bOeN, 8'h0f);
    chk(aOeN, 8'hf0);
    $display("test direction done");
  endtask

  // direction stays from t_dir: A low nibble out, B high nibble out
  task automatic t_latch;
    wr(SEL_A_CTRL, 8'h04);
    wr(SEL_A_PORT, 8'h05);
    chk(aOut, 8'h05);
    extA = 8'ha0;
    rdChk(SEL_A_PORT, 8'ha5);
    wr(SEL_B_CTRL, 8'h04);
    wr(SEL_B_PORT, 8'h30);
    extB = 8'h0c;
    rdChk(SEL_B_PORT, 8'h3c);
    chk(aOut, 8'h05);
    rdChk(SEL_A_CTRL, 8'h04);
    $display("test latch done");
  endtask

  task automatic t_select;
    logic [2:0] bad [3] = '{3'b010, 3'b100, 3'b111};
    foreach (bad[i])
    begin
      bus(1'b0, SEL_A_CTRL, 8'h03, bad[i], rv);
      bus(1'b1, SEL_A_CTRL, 8'h00, bad[i], rv);
    end
    rdChk(SEL_A_CTRL, 8'h04);
    $display("test select done");
  endtask

  task automatic t_irq;
    wr(SEL_A_CTRL, 8'h07);
    pulse(1'b0);
    chk({7'h0, aIrqOeN}, 8'h00);
    chk({7'h0, aIrqOut}, 8'h00);
    chk({7'h0, bIrqOeN}, 8'h01);
    rdChk(SEL_A_CTRL, 8'h87);
    wr(SEL_A_CTRL, 8'h07);
    rdChk(SEL_A_CTRL, 8'h87);
    rdChk(SEL_A_PORT, 8'ha5);
    chk({7'h0, aIrqOeN}, 8'h01);
    rdChk(SEL_A_CTRL, 8'h07);
    wr(SEL_A_CTRL, 8'h06);
    pulse(1'b0);
    pulse(1'b0);
    chk({7'h0, aIrqOeN}, 8'h01);
    rdChk(SEL_A_CTRL, 8'h86);
    wr(SEL_B_CTRL, 8'h07);
    pulse(1'b1);
    chk({7'h0, bIrqOeN}, 8'h00);
    chk({7'h0, bIrqOut}, 8'h00);
    $display("test interrupt done");
  endtask

  // aux line as output, then as falling-edge input feeding the second flag
  task automatic t_aux;
    wr(SEL_A_CTRL, 8'h2c);
    chk({7'h0, auxAOut}, 8'h01);
    chk({7'h0, auxAOeN}, 8'h00);
    rdChk(SEL_A_CTRL, 8'hac);
    wr(SEL_A_CTRL, 8'h24);
    chk({7'h0, auxAOut}, 8'h00);
    rdChk(SEL_A_PORT, 8'ha5);
    wr(SEL_A_CTRL, 8'h0c);
    chk({7'h0, auxAOeN}, 8'h01);
    pulse(1'b0, 1'b1);
    rdChk(SEL_A_CTRL, 8'h0c);
    pulse(1'b0, 1'b1);
    chk({7'h0, aIrqOeN}, 8'h00);
    rdChk(SEL_A_CTRL, 8'h4c);
    rdChk(SEL_A_PORT, 8'ha5);
    chk({7'h0, aIrqOeN}, 8'h01);
    rdChk(SEL_A_CTRL, 8'h0c);
    wr(SEL_B_CTRL, 8'h2c);
    chk({7'h0, auxBOut}, 8'h01);
    chk({7'h0, auxBOeN}, 8'h00);
    chk({7'h0, auxAOeN}, 8'h01);
    $display("test aux line done");
  endtask

  task automatic t_pin;
    @(negedge sys_clk);
    resetNInput = 0;
    repeat (6) @(negedge sys_clk);
    chk(aOeN, 8'hff);
    chk(bOut, 8'h00);
    chk({7'h0, bIrqOeN}, 8'h01);
    chk({7'h0, auxBOeN}, 8'h01);
    resetNInput = 1;
    repeat (6) @(negedge sys_clk);
    rdChk(SEL_B_CTRL, 8'h00);
    $display("test reset pin done");
  endtask

  task automatic give_verdict;
    $display("compares %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ==========================================
  // run
  initial
  begin
    repeat (3) @(negedge sys_clk);
    rst = 0;
    repeat (6) @(negedge sys_clk);
    t_reset();
    t_dir();
    t_latch();
    t_select();
    t_irq();
    t_aux();
    t_pin();
    give_verdict();
  end

  // the tests take about 850 cycles; this limit leaves wide margin
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    give_verdict();
  end
endmodule
